// [src/sac_top.sv]
// Control logic of the 8-bit 12-channel successive-approximation converter.
`timescale 1ns/10ps
module sac_top
   import sac_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Register port.
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // Analog front end.
   input  wire logic        comp_above,
   output logic [7:0]       dac_code,
   output logic             sample_hold,
   output logic [11:0]      chan_sel,
   // External trigger and interrupt.
   input  wire logic        ext_trigger_pin,
   output logic             conv_done_irq
);

   // Register state.
   sac_mode_s   mode_ff;
   sac_irqctl_s irqctl_ff;
   sac_state_e  state_ff;
   sac_state_e  nxt_state;
   logic [7:0]  result_ff;
   logic [7:0]  rdata_ff;
   logic [5:0]  cyc_ff;
   logic [3:0]  step_ff;
   logic [11:0] chan_ff;
   logic        sh_ff;
   logic        irq_ff;
   logic [2:0]  trig_sync_ff;

   // Address decode.
   wire         hit_mode   = (reg_addr == ADDR_MODE);
   wire         hit_result = (reg_addr == ADDR_RESULT);
   wire         hit_start  = (reg_addr == ADDR_START);
   wire         hit_irqctl = (reg_addr == ADDR_IRQCTL);
   wire         wr_mode    = reg_wr && hit_mode;
   wire         wr_start   = reg_wr && hit_start;
   wire         wr_irqctl  = reg_wr && hit_irqctl;

   // Selected timing.
   wire [5:0]   period_len = mode_ff.period_fast ? PERIOD_FAST : PERIOD_SLOW;
   wire [5:0]   sample_len = mode_ff.period_fast ? SAMPLE_FAST : SAMPLE_SLOW;
   wire [3:0]   step_len   = mode_ff.period_fast ? STEP_FAST : STEP_SLOW;

   // Trigger edge; only the second and third stages are looked at.
   wire         trig_rise  = trig_sync_ff[1] && !trig_sync_ff[2];
   wire         trig_fall  = !trig_sync_ff[1] && trig_sync_ff[2];
   wire         trig_edge  = irqctl_ff.edge_rise ? trig_rise : trig_fall;
   wire         trig_start = trig_edge && mode_ff.trig_en && irqctl_ff.pin_func;

   // Start and abort; a software abort outranks a trigger in the same cycle.
   wire         sw_start   = wr_start && reg_wdata[START_ACT_BIT];
   wire         sw_abort   = wr_start && !reg_wdata[START_ACT_BIT];
   wire         start      = !sw_abort && (sw_start || trig_start);
   wire         active     = (state_ff != ST_IDLE);

   // Phase boundaries.
   wire         sample_end = (state_ff == ST_SAMPLE) && (cyc_ff == 6'(sample_len - 6'h01));
   wire         step_pulse = (state_ff == ST_RESOLVE) && (step_ff == 4'(step_len - 4'h1));
   wire         last_cyc   = (state_ff == ST_RESOLVE) && (cyc_ff == 6'(period_len - 6'h01));
   wire         done       = last_cyc && !sw_abort && !start;

   // Done request: a completion beats a software clear in the same cycle.
   wire         req_clr    = wr_irqctl && !reg_wdata[IRQCTL_REQ_BIT];
   wire         nxt_req    = done || (irqctl_ff.done_req && !req_clr);

   // Channel decode into one-hot selects.
   wire [3:0]   chan_idx   = 4'(mode_ff.chan - CHAN_BASE);
   wire         chan_none  = (mode_ff.chan[3:2] == CHAN_NONE_HI);
   logic [11:0] chan_dec;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
         assign chan_dec[gi] = !chan_none && (chan_idx == 4'(gi));
      end
   endgenerate

   // Read mux; mode and start reserved bits read as one, interrupt-control reserved bits as zero.
   wire [7:0]   rd_mode    = {mode_ff.period_fast, mode_ff.trig_en, MODE_RSVD, mode_ff.chan};
   wire [7:0]   rd_start   = {active, START_RSVD};
   wire [7:0]   rd_irqctl  = {IRQCTL_RSVD, irqctl_ff};
   wire [7:0]   rd_mux     = hit_mode   ? rd_mode :
                             hit_start  ? rd_start :
                             hit_result ? result_ff :
                             hit_irqctl ? rd_irqctl : RDATA_IDLE;

   // Engine steps from the divider pulse; the last step lands on the final cycle.
   logic [7:0]  sar_code;
   logic [7:0]  sar_resolved;

   sac_sar_engine u_engine (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .load       (start),
      .step       (step_pulse),
      .comp_above (comp_above),
      .code       (sar_code),
      .resolved   (sar_resolved)
   );

   // Sequencer next state.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_state = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (sw_abort) begin
               nxt_state = ST_IDLE;
            end else if (start) begin
               nxt_state = ST_SAMPLE;
            end else if (sample_end) begin
               nxt_state = ST_RESOLVE;
            end
         end
         ST_RESOLVE: begin
            if (sw_abort || last_cyc) begin
               nxt_state = start ? ST_SAMPLE : ST_IDLE;
            end else if (start) begin
               nxt_state = ST_SAMPLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Sequencer state and cycle counters.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         cyc_ff   <= '0;
         step_ff  <= '0;
      end else begin
         state_ff <= nxt_state;
         cyc_ff   <= (start || !active) ? '0 : 6'(cyc_ff + 6'h01);
         step_ff  <= (state_ff != ST_RESOLVE || step_pulse || start) ? '0 : 4'(step_ff + 4'h1);
      end
   end

   // Mode and interrupt control registers.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_ff   <= MODE_RST_S;
         irqctl_ff <= IRQCTL_RST_S;
      end else begin
         if (wr_mode) begin
            mode_ff <= {reg_wdata[MODE_FAST_BIT], reg_wdata[MODE_TRIG_BIT], reg_wdata[3:0]};
         end
         irqctl_ff.done_req <= nxt_req;
         if (wr_irqctl) begin
            irqctl_ff.edge_rise <= reg_wdata[3];
            irqctl_ff.pin_func  <= reg_wdata[2];
            irqctl_ff.irq_en    <= reg_wdata[1];
         end
      end
   end

   // Result has no reset so its contents survive one; it holds until the next completion.
   always_ff @(posedge clk) begin
      if (done) begin
         result_ff <= sar_resolved;
      end
   end

   // Synchroniser, registered outputs and read data.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trig_sync_ff <= '0;
         rdata_ff     <= RDATA_IDLE;
         chan_ff      <= '0;
         sh_ff        <= 1'b0;
         irq_ff       <= 1'b0;
      end else begin
         trig_sync_ff <= {trig_sync_ff[1:0], ext_trigger_pin};
         rdata_ff     <= reg_rd ? rd_mux : RDATA_IDLE;
         chan_ff      <= chan_dec;
         sh_ff        <= (nxt_state == ST_SAMPLE);
         irq_ff       <= nxt_req && irqctl_ff.irq_en;
      end
   end

   assign reg_rdata     = rdata_ff;
   assign dac_code      = sar_code;
   assign sample_hold   = sh_ff;
   assign chan_sel      = chan_ff;
   assign conv_done_irq = irq_ff;

endmodule

// [src/sac_pkg.sv]
// Shared constants, register map and types for the successive-approximation converter control.
// Contract
// - Result register is 8-bit read-only, readable anytime, undefined during conversion.
// - Result holds the finished 8-bit code until the next conversion completes.
// - Reset leaves the result register untouched.
// - Mode register resets to 0x30.
// - Mode bit 7 picks the period: 0 gives 62 cycles, 1 gives 31.
// - Mode bit 6 gates external trigger starts.
// - Mode bits 5 and 4 always read one and ignore writes.
// - Channel field: 00xx none, 0100..1111 select inputs 0..11.
// - Writing one to start bit 7, or the enabled trigger edge, starts a conversion.
// - At completion the result loads and the active flag clears together.
// - Active flag reads busy state; writing zero aborts; resets to zero.
// - Start register bits 6..0 always read one and ignore writes.
// - Result found by successive approximation, MSB first, 8-bit code.
// - Active flag falling at completion sets the done request flag.
// - Interrupt raised only while the done interrupt enable is one.
// - Trigger needs pin function bit and trigger enable; edge select picks polarity.
package sac_pkg;

   // Register addresses on the plain register port.
   localparam logic [15:0] ADDR_MODE   = 16'hFFC4;
   localparam logic [15:0] ADDR_RESULT = 16'hFFC5;
   localparam logic [15:0] ADDR_START  = 16'hFFC6;
   localparam logic [15:0] ADDR_IRQCTL = 16'hFFC7;

   // Field positions and fixed values.
   localparam int          MODE_FAST_BIT   = 7;
   localparam int          MODE_TRIG_BIT   = 6;
   localparam int          START_ACT_BIT   = 7;
   localparam int          IRQCTL_REQ_BIT  = 0;
   localparam logic [7:0]  MODE_RST        = 8'h30;
   localparam logic [1:0]  MODE_RSVD       = 2'h3;
   localparam logic [6:0]  START_RSVD      = 7'h7F;
   localparam logic [3:0]  IRQCTL_RSVD     = 4'h0;
   localparam logic [7:0]  RDATA_IDLE      = 8'h00;

   // Conversion timing in clock cycles.
   localparam int          NUM_BITS        = 8;
   localparam logic [5:0]  PERIOD_SLOW     = 6'h3E;
   localparam logic [5:0]  PERIOD_FAST     = 6'h1F;
   localparam logic [3:0]  STEP_SLOW       = 4'h6;
   localparam logic [3:0]  STEP_FAST       = 4'h3;
   localparam logic [5:0]  SAMPLE_SLOW     = 6'(PERIOD_SLOW - NUM_BITS * STEP_SLOW);
   localparam logic [5:0]  SAMPLE_FAST     = 6'(PERIOD_FAST - NUM_BITS * STEP_FAST);

   // Channel decode.
   localparam int          NUM_CHAN        = 12;
   localparam logic [1:0]  CHAN_NONE_HI    = 2'h0;
   localparam logic [3:0]  CHAN_BASE       = 4'h4;

   // Approximation register seed.
   localparam logic [7:0]  SAR_MSB         = 8'h80;

   typedef struct packed {
      logic       period_fast;
      logic       trig_en;
      logic [3:0] chan;
   } sac_mode_s;

   typedef struct packed {
      logic edge_rise;
      logic pin_func;
      logic irq_en;
      logic done_req;
   } sac_irqctl_s;

   localparam sac_mode_s   MODE_RST_S   = '{period_fast: MODE_RST[7], trig_en: MODE_RST[6], chan: MODE_RST[3:0]};
   localparam sac_irqctl_s IRQCTL_RST_S = '{edge_rise: 1'b0, pin_func: 1'b0, irq_en: 1'b0, done_req: 1'b0};

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h1,
      ST_SAMPLE  = 3'h2,
      ST_RESOLVE = 3'h4
   } sac_state_e;

endpackage

// [src/sac_sar_engine.sv]
// Successive-approximation register that resolves one bit per step, MSB first.
`timescale 1ns/10ps
module sac_sar_engine
   import sac_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Control.
   input  wire logic       load,
   input  wire logic       step,
   input  wire logic       comp_above,
   // Trial code to the ladder and the code with the current bit decided.
   output logic [7:0]      code,
   output logic [7:0]      resolved
);

   logic [7:0] code_ff;
   logic [7:0] ptr_ff;
   logic [7:0] nxt_code;
   logic [7:0] nxt_ptr;

   // The bit under trial stays only when the input sits at or above the trial level.
   assign resolved = comp_above ? code_ff : (code_ff & ~ptr_ff);
   assign nxt_code = load ? SAR_MSB : (step ? (resolved | (ptr_ff >> 1)) : code_ff);
   assign nxt_ptr  = load ? SAR_MSB : (step ? (ptr_ff >> 1) : ptr_ff);
   assign code     = code_ff;

   // Trial code and bit pointer.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         code_ff <= SAR_MSB;
         ptr_ff  <= SAR_MSB;
      end else begin
         code_ff <= nxt_code;
         ptr_ff  <= nxt_ptr;
      end
   end

endmodule

// [verif/sac_props.sv]
// Port checker for the converter control block, bound to its top module.
`timescale 1ns/10ps
module sac_props
   import sac_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Register port.
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_rdata,
   // Analog side, trigger and interrupt.
   input  wire logic        comp_above,
   input  wire logic [7:0]  dac_code,
   input  wire logic        sample_hold,
   input  wire logic [11:0] chan_sel,
   input  wire logic        ext_trigger_pin,
   input  wire logic        conv_done_irq
);
   // Decoded strobes; a start write with bit 7 low is an abort.
   wire wr_start = reg_wr && reg_addr == ADDR_START;
   wire mapped   = reg_addr inside {ADDR_MODE, ADDR_RESULT, ADDR_START, ADDR_IRQCTL};
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // The channel decode is checked two edges on, since the select is registered from the mode register.
   property p_chan;
      logic [3:0] c;
      (reg_wr && reg_addr == ADDR_MODE, c = reg_wdata[3:0]) |->
         ##2 chan_sel == ((c[3:2] == CHAN_NONE_HI) ? 12'h000 : 12'h001 << (c - CHAN_BASE));
   endproperty
   a_chan_decode: assert property (p_chan)
      else $error("channel select does not match mode field");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == RDATA_IDLE)
      else $error("read data not idle outside a read");
   a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == RDATA_IDLE)
      else $error("unmapped read not zero");
   a_start_rsvd_ones: assert property (reg_rd && reg_addr == ADDR_START |=> reg_rdata[6:0] == START_RSVD)
      else $error("start reserved bits not one");
   a_mode_rsvd_ones: assert property (reg_rd && reg_addr == ADDR_MODE |=> reg_rdata[5:4] == MODE_RSVD)
      else $error("mode reserved bits not one");
   a_start_sampling: assert property (wr_start && reg_wdata[7] |=> (sample_hold && dac_code == SAR_MSB)[*7])
      else $error("start did not begin sampling at the seed code");
   a_abort_idle: assert property (wr_start && !reg_wdata[7] |=> !sample_hold)
      else $error("abort left sampling running");
   a_sample_dac_hold: assert property (sample_hold && $past(sample_hold) |-> $stable(dac_code))
      else $error("trial code moved during sampling");
   // Main scenarios.
   c_start: cover property (wr_start && reg_wdata[7]);
   c_abort: cover property (wr_start && !reg_wdata[7]);
   c_irq: cover property ($rose(conv_done_irq));
endmodule

bind sac_top sac_props i_props (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_above(comp_above), .dac_code(dac_code),
   .sample_hold(sample_hold), .chan_sel(chan_sel), .ext_trigger_pin(ext_trigger_pin),
   .conv_done_irq(conv_done_irq));

// [verif/sac_analog_model.sv]
// Analog source model: fixed input levels per channel and the comparator.
`timescale 1ns/10ps
module sac_analog_model (
   // Trial code and channel select from the converter.
   input  wire logic [7:0]  dac_code,
   input  wire logic [11:0] chan_sel,
   // Comparator decision back to the converter.
   output logic             comp_above
);
   logic [7:0] level;
   // Channel k holds k*21+7 so every code bit is exercised; an unselected input sits at ground.
   always_comb begin
      level = 8'h00;
      for (int k = 0; k < 12; k++) begin
         if (chan_sel[k]) begin
            level = 8'(k * 21 + 7);
         end
      end
   end
   // High when the held input is at or above the trial code.
   assign comp_above = level >= dac_code;
endmodule

// [verif/testbench.sv]
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module testbench import sac_pkg::*;;
   logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ext_trigger_pin = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata, dac_code, rd;
   logic [11:0] chan_sel;
   logic        comp_above, sample_hold, conv_done_irq;
   int          n_mismatch = 0, check_count = 0;

   // Clock at 40 MHz.
   initial begin
      forever #12.5 clk = ~clk;
   end

   sac_top i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_above(comp_above), .dac_code(dac_code),
      .sample_hold(sample_hold), .chan_sel(chan_sel), .ext_trigger_pin(ext_trigger_pin),
      .conv_done_irq(conv_done_irq));
   sac_analog_model i_src (.dac_code(dac_code), .chan_sel(chan_sel), .comp_above(comp_above));

   // Compare and count.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe, then one idle edge so a following call never re-drives the strobe in one step.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   // Read strobe, then take the data in the following cycle only.
   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rd = reg_rdata;
      @(posedge clk);
      chk(rd, exp);
   endtask

   // Software conversion; odd fields use the short period, field bit 1 enables the interrupt.
   task automatic conv(input logic [3:0] ch);
      logic [7:0] lvl;
      int         p;
      lvl = (ch[3:2] == 2'b00) ? 8'h00 : 8'(({28'h0, ch} - 4) * 21 + 7);
      p = ch[0] ? 31 : 62;
      wr(ADDR_IRQCTL, {6'h00, ch[1], 1'b0});
      wr(ADDR_MODE, {ch[0], 3'b000, ch});
      rdc(ADDR_MODE, {ch[0], 3'b011, ch});
      wr(ADDR_START, 8'h80);
      repeat (p - 2) @(posedge clk);
      rdc(ADDR_START, 8'hFF);
      rdc(ADDR_START, 8'h7F);
      rdc(ADDR_RESULT, lvl);
      rdc(ADDR_IRQCTL, {6'h00, ch[1], 1'b1});
      chk({7'h00, conv_done_irq}, {7'h00, ch[1]});
   endtask

   // A rising pin edge under the given interrupt-control and mode settings.
   task automatic trig(input logic [7:0] irq, input logic [7:0] mode, input logic [7:0] exp);
      wr(ADDR_IRQCTL, irq);
      wr(ADDR_MODE, mode);
      ext_trigger_pin <= 1'b0;
      repeat (6) @(posedge clk);
      ext_trigger_pin <= 1'b1;
      repeat (6) @(posedge clk);
      rdc(ADDR_START, exp);
   endtask

   // Print the counts and the verdict, then stop.
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(ADDR_MODE, MODE_RST);
      rdc(ADDR_START, 8'h7F);
      rdc(16'hFFC8, 8'h00);
      for (int c = 3; c < 16; c++) begin
         conv(4'(c));
      end
      wr(ADDR_IRQCTL, 8'h00);
      wr(ADDR_START, 8'h80);
      repeat (10) @(posedge clk);
      wr(ADDR_START, 8'h00);
      rdc(ADDR_START, 8'h7F);
      rdc(ADDR_RESULT, 8'hEE);
      rdc(ADDR_IRQCTL, 8'h00);
      trig(8'h08, 8'h74, 8'h7F);
      trig(8'h0C, 8'h34, 8'h7F);
      trig(8'h0C, 8'h74, 8'hFF);
      repeat (60) @(posedge clk);
      rdc(ADDR_RESULT, 8'h07);
      rdc(ADDR_IRQCTL, 8'h0D);
      trig(8'h04, 8'h74, 8'hFF);
      wr(ADDR_START, 8'h00);
      wr(ADDR_MODE, 8'hC5);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(ADDR_MODE, MODE_RST);
      rdc(ADDR_RESULT, 8'h07);
      finish_test();
   end

   // Watchdog, well beyond the expected run of about 1000 cycles.
   initial begin
      #(25 * 20000);
      n_mismatch++;
      finish_test();
   end
endmodule
